//--- design/ptr_totaliser.sv
/*
  Pulse totaliser and rate meter with APB register access.
  Assumes an APB master, pulse input and buttons synchronous to core_clk.
*/
// Implementation choices: the register offsets and the APB register port.
//
// Contract
// - Contact inputs need high and low phases of 1600, 3200 or 400 us.
// - Other inputs need phases of 40, 350 or 5 us.
// - Three debounce levels pick the qualification time.
// - Below 0.01 Hz the rate reads zero.
// - Edge option chooses rising or falling transition per input kind.
// - Direction chooses increment or decrement of the total.
// - Local or remote reset loads the total with the preset value.
// - Total clear buttons held over 2 s in display mode clear total.
// - Grand total buttons held over 10 s in display mode clear it.
// - Menu grand total clear runs only after a yes confirmation.
// - Four digit access code guards configuration; 0000 disables it.
// - Factory restore runs only after explicit confirmation.
// - Rate per second, minute or hour via a three option setting.
// - Two filter digits 0 to 9; first sets smoothing.
// - Second digit is a deviation limit that bypasses the filter.
// - Display refresh is one of six intervals, 0.5 to 5 s.
// - Refresh interval only gates the displays, nothing else.
// - Six input kinds; contact uses contact timing, proximity inverts the edge mapping.
// - Timebase multiplies the rate by 1, 60 or 3600.
// - Counting goes on while in configuration.
// - A minute without activity in configuration discards the changes.
`timescale 1ns/1ns
`default_nettype none
module ptr_totaliser import ptr_pkg::*; #(
  parameter int CONTACT_DEF_CYC = PTR_CONTACT_DEF_US * PTR_CLK_PER_US,
  parameter int CONTACT_HEAVY_CYC = PTR_CONTACT_HEAVY_US * PTR_CLK_PER_US,
  parameter int CONTACT_LIGHT_CYC = PTR_CONTACT_LIGHT_US * PTR_CLK_PER_US,
  parameter int OTHER_HEAVY_CYC = PTR_OTHER_HEAVY_US * PTR_CLK_PER_US,
  parameter longint TOTAL_HOLD_CYC = longint'(PTR_TOTAL_HOLD_MS) * PTR_CLK_PER_MS,
  parameter longint GRAND_HOLD_CYC = longint'(PTR_GRAND_HOLD_MS) * PTR_CLK_PER_MS,
  parameter longint CFG_IDLE_CYC = longint'(PTR_CFG_IDLE_MS) * PTR_CLK_PER_MS,
  parameter longint HALF_SEC_CYC = longint'(PTR_HALF_SEC_MS) * PTR_CLK_PER_MS,
  parameter longint RATE_ZERO_CYC = longint'(PTR_RATE_ZERO_MS) * PTR_CLK_PER_MS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transducer and panel
  input wire logic pulseIn,
  input wire logic remoteReset,
  input wire logic btnUp,
  input wire logic btnDown,
  input wire logic btnEnter,
  // Displays
  output logic [31:0] dispTotal,
  output logic [31:0] dispRate,
  output logic configMode
);
  typedef enum logic [1:0] {
    DIV_IDLE = 2'b00, DIV_RUN = 2'b01, DIV_FILT = 2'b10
  } ptr_div_type;

  typedef struct packed {
    ptr_ctrl_type ctrl;
    ptr_ctrl_type ctrlSh;
    logic [7:0] filt;
    logic [7:0] filtSh;
    logic [31:0] preset;
    logic [31:0] presetSh;
    logic [15:0] scale;
    logic [15:0] scaleSh;
    logic [15:0] code;
    logic [15:0] codeSh;
    logic cfg;
    logic pendGt;
    logic pendFac;
    logic [PTR_LONG_W-1:0] idleCnt;
    logic [31:0] total;
    logic [31:0] grand;
    logic lastQual;
    logic [PTR_LONG_W-1:0] periodCnt;
    logic havePeriod;
    logic rateZero;
    ptr_div_type divState;
    logic [5:0] bitCnt;
    logic [PTR_REM_W-1:0] rem;
    logic [PTR_NUM_W-1:0] quo;
    logic [PTR_DEN_W-1:0] den;
    logic [31:0] rawRate;
    logic [31:0] filtRate;
    logic [1:0][PTR_LONG_W-1:0] hold;
    logic [PTR_LONG_W-1:0] halfCnt;
    logic [3:0] halfTicks;
    logic [31:0] dispTotal;
    logic [31:0] dispRate;
    logic [31:0] prdata;
  } ptr_state_type;

  ptr_state_type st_r;
  ptr_state_type st_nxt;
  ptr_qual_if qualIf ();

  // Minimum phase width for the current kind and level
  function automatic logic [PTR_DB_W-1:0] minWidth(input ptr_ctrl_type c);
    logic contact;
    contact = (c.inType == SWITCH_CONTACT_INPUT);
    case (c.debounce)
      DB_HEAVY: minWidth = contact ? PTR_DB_W'(CONTACT_HEAVY_CYC)
                                   : PTR_DB_W'(OTHER_HEAVY_CYC);
      DB_LIGHT: minWidth = contact ? PTR_DB_W'(CONTACT_LIGHT_CYC)
                                   : PTR_DB_W'(PTR_OTHER_LIGHT_CYC);
      default: minWidth = contact ? PTR_DB_W'(CONTACT_DEF_CYC)
                                  : PTR_DB_W'(PTR_OTHER_DEF_CYC);
    endcase
  endfunction

  // Rising level counts for edge one, except proximity (current falls)
  function automatic logic countsRising(input ptr_ctrl_type c);
    countsRising = (~c.edgeTwo) ^ (c.inType == PROXIMITY_DETECTOR_INPUT);
  endfunction

  // Multiplier for the selected timebase
  function automatic logic [11:0] timeMult(input ptr_timebase_type t);
    case (t)
      TB_MIN: timeMult = PTR_MULT_MIN;
      TB_HOUR: timeMult = PTR_MULT_HOUR;
      default: timeMult = PTR_MULT_SEC;
    endcase
  endfunction

  // Address decode used by the error answer and the write enable
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a[1:0] == 2'h0) && (a <= PTR_OFS_DRATE);
  endfunction

  assign qualIf.rawLevel = pulseIn;
  assign qualIf.minWidth = minWidth(st_r.ctrl);

  ptr_debounce uDebounce (
    .core_clk(core_clk),
    .reset(reset),
    .qual(qualIf.filter)
  );

  // Next-state logic for the whole block
  always_comb begin
    logic apbWr;
    logic apbAcc;
    logic cntEdge;
    logic tick;
    logic [1:0] held;
    logic [1:0][PTR_LONG_W-1:0] lim;
    logic [1:0] fire;
    logic [PTR_REM_W-1:0] remS;
    logic [32:0] diff;
    logic [32:0] mag;
    logic [35:0] limit;
    logic [32:0] step;
    logic [31:0] rd;
    apbWr = 1'b0;
    apbAcc = 1'b0;
    cntEdge = 1'b0;
    tick = 1'b0;
    held = '0;
    lim = '0;
    fire = '0;
    remS = '0;
    diff = '0;
    mag = '0;
    limit = '0;
    step = '0;
    rd = '0;
    st_nxt = st_r;
    apbAcc = psel & penable;
    apbWr = apbAcc & pwrite & isMapped(paddr);

    // Qualified counting edge; counting ignores the configuration state
    st_nxt.lastQual = qualIf.qualLevel;
    cntEdge = countsRising(st_r.ctrl) ? (qualIf.qualLevel & ~st_r.lastQual)
                                      : (~qualIf.qualLevel & st_r.lastQual);
    if (cntEdge) begin
      st_nxt.total = st_r.ctrl.countDirectionSelect ? st_r.total - 1'b1
                                                    : st_r.total + 1'b1;
      st_nxt.grand = st_r.grand + 1'b1;
    end

    // Panel clears: only in display mode, fire once per hold
    lim[0] = PTR_LONG_W'(TOTAL_HOLD_CYC);
    lim[1] = PTR_LONG_W'(GRAND_HOLD_CYC);
    held[0] = btnUp & btnDown & st_r.ctrl.totalPanelClear & ~st_r.cfg;
    held[1] = btnEnter & btnDown & st_r.ctrl.grandTotalPanelClear & ~st_r.cfg;
    for (int i = 0; i < 2; i++) begin
      if (!held[i]) begin
        st_nxt.hold[i] = '0;
      end else if (st_r.hold[i] <= lim[i]) begin
        st_nxt.hold[i] = st_r.hold[i] + 1'b1;
        fire[i] = (st_r.hold[i] == lim[i]);
      end
    end
    if (fire[0] || remoteReset) begin
      st_nxt.total = st_r.preset;
    end
    if (fire[1]) begin
      st_nxt.grand = '0;
    end

    // Edge-to-edge period; too long an interval forces the rate to zero
    if (cntEdge) begin
      st_nxt.periodCnt = '0;
      st_nxt.havePeriod = 1'b1;
      // An edge during a running division starts no division but still restarts the period count
      if (st_r.havePeriod && st_r.divState == DIV_IDLE) begin
        st_nxt.divState = DIV_RUN;
        st_nxt.bitCnt = '0;
        st_nxt.rem = '0;
        st_nxt.quo = PTR_NUM_W'(PTR_CLK_HZ) * PTR_NUM_W'(timeMult(st_r.ctrl.rateTimeMultiplier))
                     * PTR_NUM_W'(PTR_RATE_FRAC);
        st_nxt.den = PTR_DEN_W'(st_r.periodCnt + 1'b1)
                     * PTR_DEN_W'((st_r.scale == '0) ? 16'h0001 : st_r.scale);
      end
    end else if (st_r.periodCnt >= PTR_LONG_W'(RATE_ZERO_CYC)) begin
      st_nxt.rateZero = 1'b1;
      st_nxt.havePeriod = 1'b0;
    end else begin
      st_nxt.periodCnt = st_r.periodCnt + 1'b1;
    end

    // Restoring divider, one quotient bit per cycle
    case (st_r.divState)
      DIV_RUN: begin
        remS = {st_r.rem[PTR_REM_W-2:0], st_r.quo[PTR_NUM_W-1]};
        st_nxt.quo = {st_r.quo[PTR_NUM_W-2:0], 1'b0};
        if (remS >= PTR_REM_W'(st_r.den)) begin
          remS = remS - PTR_REM_W'(st_r.den);
          st_nxt.quo[0] = 1'b1;
        end
        st_nxt.rem = remS;
        st_nxt.bitCnt = st_r.bitCnt + 1'b1;
        if (st_r.bitCnt == 6'(PTR_NUM_W - 1)) begin
          st_nxt.divState = DIV_FILT;
          st_nxt.rawRate = (st_nxt.quo[PTR_NUM_W-1:32] != '0) ? '1
                                                          : st_nxt.quo[31:0];
        end
      end
      DIV_FILT: begin
        st_nxt.divState = DIV_IDLE;
        st_nxt.rateZero = 1'b0;
        diff = {1'b0, st_r.rawRate} - {1'b0, st_r.filtRate};
        mag = diff[32] ? (~diff + 1'b1) : diff;
        limit = 36'(st_r.filtRate >> 4) * 36'(st_r.filt[3:0]);
        step = 33'($signed(diff) >>> st_r.filt[7:4]);
        if (st_r.filt[3:0] != 4'h0 && 36'(mag) > limit) begin
          st_nxt.filtRate = st_r.rawRate;
        end else if (st_r.filt[7:4] == 4'h0) begin
          st_nxt.filtRate = st_r.rawRate;
        end else begin
          st_nxt.filtRate = st_r.filtRate + step[31:0];
        end
      end
      default: ;
    endcase
    // Zero forcing wins over a result in flight
    if (st_r.rateZero && st_r.divState != DIV_FILT) begin
      st_nxt.rawRate = '0;
      st_nxt.filtRate = '0;
    end

    // Display refresh in half-second steps; only the displays wait for it
    if (st_r.halfCnt >= PTR_LONG_W'(HALF_SEC_CYC - 1)) begin
      st_nxt.halfCnt = '0;
      st_nxt.halfTicks = st_r.halfTicks + 1'b1;
      if ((st_r.halfTicks + 1'b1) >= ptr_refresh_halves(st_r.ctrl.displayRefreshInterval)) begin
        tick = 1'b1;
        st_nxt.halfTicks = '0;
      end
    end else begin
      st_nxt.halfCnt = st_r.halfCnt + 1'b1;
    end
    if (tick) begin
      st_nxt.dispTotal = st_r.total;
      st_nxt.dispRate = st_r.filtRate;
    end

    // Configuration idle timeout drops unsaved shadow values
    if (st_r.cfg) begin
      if (apbAcc || btnUp || btnDown || btnEnter) begin
        st_nxt.idleCnt = '0;
      end else if (st_r.idleCnt >= PTR_LONG_W'(CFG_IDLE_CYC)) begin
        st_nxt.cfg = 1'b0;
        st_nxt.pendGt = 1'b0;
        st_nxt.pendFac = 1'b0;
      end else begin
        st_nxt.idleCnt = st_r.idleCnt + 1'b1;
      end
    end

    // Register writes; settings land in the shadow copy until saved
    if (apbWr) begin
      case (paddr)
        PTR_OFS_CTRL: if (st_r.cfg) st_nxt.ctrlSh = ptr_ctrl_type'(pwdata[13:0]);
        PTR_OFS_FILTER: begin
          // Digits above nine are refused, keeping each digit in range
          if (st_r.cfg && pwdata[7:4] <= 4'h9 && pwdata[3:0] <= 4'h9) begin
            st_nxt.filtSh = pwdata[7:0];
          end
        end
        PTR_OFS_PRESET: if (st_r.cfg) st_nxt.presetSh = pwdata;
        PTR_OFS_SCALE: if (st_r.cfg) st_nxt.scaleSh = pwdata[15:0];
        PTR_OFS_CODE: if (st_r.cfg) st_nxt.codeSh = pwdata[15:0];
        PTR_OFS_UNLOCK: begin
          if (!st_r.cfg && (st_r.code == '0 || pwdata[15:0] == st_r.code)) begin
            st_nxt.cfg = 1'b1;
            st_nxt.idleCnt = '0;
            st_nxt.ctrlSh = st_r.ctrl;
            st_nxt.filtSh = st_r.filt;
            st_nxt.presetSh = st_r.preset;
            st_nxt.scaleSh = st_r.scale;
            st_nxt.codeSh = st_r.code;
          end
        end
        PTR_OFS_CMD: begin
          if (st_r.cfg) begin
            if (pwdata[PTR_CMD_GT_CLR]) st_nxt.pendGt = 1'b1;
            if (pwdata[PTR_CMD_FACTORY]) st_nxt.pendFac = 1'b1;
            if (pwdata[PTR_CMD_CONFIRM] && st_r.pendGt) begin
              st_nxt.grand = '0;
              st_nxt.pendGt = 1'b0;
            end
            if (pwdata[PTR_CMD_CONFIRM] && st_r.pendFac) begin
              st_nxt.pendFac = 1'b0;
              st_nxt.ctrl = PTR_CTRL_DEFAULT;
              st_nxt.ctrlSh = PTR_CTRL_DEFAULT;
              st_nxt.filt = PTR_FILTER_DEFAULT;
              st_nxt.filtSh = PTR_FILTER_DEFAULT;
              st_nxt.preset = PTR_PRESET_DEFAULT;
              st_nxt.presetSh = PTR_PRESET_DEFAULT;
              st_nxt.scale = PTR_SCALE_DEFAULT;
              st_nxt.scaleSh = PTR_SCALE_DEFAULT;
              st_nxt.code = PTR_CODE_DEFAULT;
              st_nxt.codeSh = PTR_CODE_DEFAULT;
            end
            if (pwdata[PTR_CMD_SAVE]) begin
              st_nxt.cfg = 1'b0;
              st_nxt.ctrl = st_r.ctrlSh;
              st_nxt.filt = st_r.filtSh;
              st_nxt.preset = st_r.presetSh;
              st_nxt.scale = st_r.scaleSh;
              st_nxt.code = st_r.codeSh;
            end
            if (pwdata[PTR_CMD_SAVE] || pwdata[PTR_CMD_ABORT]) begin
              st_nxt.cfg = pwdata[PTR_CMD_SAVE] ? 1'b0 : 1'b0;
              st_nxt.pendGt = 1'b0;
              st_nxt.pendFac = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end

    // Read data registered in the setup phase, steady through access
    case (paddr)
      PTR_OFS_CTRL: rd = {18'h0_0000, st_r.cfg ? st_r.ctrlSh : st_r.ctrl};
      PTR_OFS_FILTER: rd = {24'h00_0000, st_r.cfg ? st_r.filtSh : st_r.filt};
      PTR_OFS_PRESET: rd = st_r.cfg ? st_r.presetSh : st_r.preset;
      PTR_OFS_SCALE: rd = {16'h0000, st_r.cfg ? st_r.scaleSh : st_r.scale};
      PTR_OFS_STATUS: rd = {27'h000_0000, st_r.rateZero, qualIf.qualLevel,
                            st_r.pendFac, st_r.pendGt, st_r.cfg};
      PTR_OFS_TOTAL: rd = st_r.total;
      PTR_OFS_GRAND: rd = st_r.grand;
      PTR_OFS_RATE: rd = st_r.filtRate;
      PTR_OFS_DTOTAL: rd = st_r.dispTotal;
      PTR_OFS_DRATE: rd = st_r.dispRate;
      default: rd = '0; // Code, unlock and command read as zero
    endcase
    if (psel && !penable) begin
      st_nxt.prdata = rd;
    end
  end

  // State register; settings come up at factory values
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
      st_r.ctrl <= PTR_CTRL_DEFAULT;
      st_r.ctrlSh <= PTR_CTRL_DEFAULT;
      st_r.filt <= PTR_FILTER_DEFAULT;
      st_r.filtSh <= PTR_FILTER_DEFAULT;
      st_r.scale <= PTR_SCALE_DEFAULT;
      st_r.scaleSh <= PTR_SCALE_DEFAULT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Zero wait state answer
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~isMapped(paddr);
  assign prdata = st_r.prdata;
  assign dispTotal = st_r.dispTotal;
  assign dispRate = st_r.dispRate;
  assign configMode = st_r.cfg;
endmodule // ptr_totaliser
`default_nettype wire

//--- inc/ptr_pkg.sv
/*
  Shared constants, field layouts and types of the pulse totaliser.
  Assumes a 50 MHz core clock; long counts are derived in the top module.
*/
`default_nettype none
package ptr_pkg;
  // Clock rate
  localparam int PTR_CLK_HZ = 50_000_000;
  localparam int PTR_CLK_PER_US = PTR_CLK_HZ / 1_000_000;
  localparam int PTR_CLK_PER_MS = PTR_CLK_HZ / 1_000;
  // Debounce minimum phase widths in microseconds
  localparam int PTR_CONTACT_DEF_US = 1600;
  localparam int PTR_CONTACT_HEAVY_US = 3200;
  localparam int PTR_CONTACT_LIGHT_US = 400;
  localparam int PTR_OTHER_DEF_US = 40;
  localparam int PTR_OTHER_HEAVY_US = 350;
  localparam int PTR_OTHER_LIGHT_US = 5;
  localparam int PTR_OTHER_DEF_CYC = PTR_OTHER_DEF_US * PTR_CLK_PER_US;
  localparam int PTR_OTHER_LIGHT_CYC = PTR_OTHER_LIGHT_US * PTR_CLK_PER_US;
  // Other times in milliseconds
  localparam int PTR_TOTAL_HOLD_MS = 2000;
  localparam int PTR_GRAND_HOLD_MS = 10_000;
  localparam int PTR_CFG_IDLE_MS = 60_000;
  localparam int PTR_HALF_SEC_MS = 500;
  localparam int PTR_RATE_ZERO_MS = 100_000; // Period of 0.01 Hz
  // Widths
  localparam int PTR_DB_W = 18;
  localparam int PTR_LONG_W = 33;
  localparam int PTR_NUM_W = 56;
  localparam int PTR_DEN_W = 49;
  localparam int PTR_REM_W = 50;
  localparam int PTR_RATE_FRAC = 10_000; // Rate and scale both in hundredths
  // Timebase multipliers
  localparam logic [11:0] PTR_MULT_SEC = 12'h001;
  localparam logic [11:0] PTR_MULT_MIN = 12'h03C;
  localparam logic [11:0] PTR_MULT_HOUR = 12'hE10;
  // Register byte offsets
  localparam logic [7:0] PTR_OFS_CTRL = 8'h00;
  localparam logic [7:0] PTR_OFS_FILTER = 8'h04;
  localparam logic [7:0] PTR_OFS_PRESET = 8'h08;
  localparam logic [7:0] PTR_OFS_SCALE = 8'h0C;
  localparam logic [7:0] PTR_OFS_CODE = 8'h10;
  localparam logic [7:0] PTR_OFS_UNLOCK = 8'h14;
  localparam logic [7:0] PTR_OFS_CMD = 8'h18;
  localparam logic [7:0] PTR_OFS_STATUS = 8'h1C;
  localparam logic [7:0] PTR_OFS_TOTAL = 8'h20;
  localparam logic [7:0] PTR_OFS_GRAND = 8'h24;
  localparam logic [7:0] PTR_OFS_RATE = 8'h28;
  localparam logic [7:0] PTR_OFS_DTOTAL = 8'h2C;
  localparam logic [7:0] PTR_OFS_DRATE = 8'h30;
  // Command bits
  localparam int PTR_CMD_GT_CLR = 0;
  localparam int PTR_CMD_FACTORY = 1;
  localparam int PTR_CMD_CONFIRM = 2;
  localparam int PTR_CMD_SAVE = 3;
  localparam int PTR_CMD_ABORT = 4;
  // Input kinds
  typedef enum logic [2:0] {
    OPEN_COLLECTOR_INPUT = 3'h0, LOW_VOLTAGE_PULSE_INPUT = 3'h1,
    HIGH_VOLTAGE_PULSE_INPUT = 3'h2, MAGNETIC_PICKOFF_INPUT = 3'h3,
    PROXIMITY_DETECTOR_INPUT = 3'h4, SWITCH_CONTACT_INPUT = 3'h5
  } ptr_input_type;
  typedef enum logic [1:0] {
    DB_DEFAULT = 2'h0, DB_HEAVY = 2'h1, DB_LIGHT = 2'h2
  } ptr_debounce_type;
  typedef enum logic [1:0] {
    TB_SEC = 2'h0, TB_MIN = 2'h1, TB_HOUR = 2'h2
  } ptr_timebase_type;
  // Control register layout, bit 13 down to bit 0
  typedef struct packed {
    logic grandTotalPanelClear;
    logic totalPanelClear;
    logic [2:0] displayRefreshInterval;
    ptr_timebase_type rateTimeMultiplier;
    logic countDirectionSelect; // 1 counts down
    logic edgeTwo;
    ptr_debounce_type debounce;
    ptr_input_type inType;
  } ptr_ctrl_type;
  localparam ptr_ctrl_type PTR_CTRL_DEFAULT = '{1'b0, 1'b0, 3'h0, TB_SEC,
    1'b0, 1'b0, DB_DEFAULT, OPEN_COLLECTOR_INPUT};
  localparam logic [7:0] PTR_FILTER_DEFAULT = 8'h24;
  localparam logic [15:0] PTR_SCALE_DEFAULT = 16'h0064;
  localparam logic [31:0] PTR_PRESET_DEFAULT = 32'h0000_0000;
  localparam logic [15:0] PTR_CODE_DEFAULT = 16'h0000;

  // Refresh interval in half seconds: 0.5, 1, 2, 3, 4, 5 s
  function automatic logic [3:0] ptr_refresh_halves(input logic [2:0] idx);
    case (idx)
      3'h1: ptr_refresh_halves = 4'h2;
      3'h2: ptr_refresh_halves = 4'h4;
      3'h3: ptr_refresh_halves = 4'h6;
      3'h4: ptr_refresh_halves = 4'h8;
      3'h5: ptr_refresh_halves = 4'hA;
      default: ptr_refresh_halves = 4'h1;
    endcase
  endfunction
endpackage
`default_nettype wire

//--- inc/ptr_qual_if.sv
/*
  Carrier between the totaliser and its input debounce qualifier.
  Assumes the owner drives the raw level and the selected width.
*/
`timescale 1ns/1ns
`default_nettype none
interface ptr_qual_if import ptr_pkg::*; ();
  logic rawLevel;
  logic [PTR_DB_W-1:0] minWidth;
  logic qualLevel;
  modport owner(output rawLevel, output minWidth, input qualLevel);
  modport filter(input rawLevel, input minWidth, output qualLevel);
endinterface
`default_nettype wire

//--- design/ptr_debounce.sv
/*
  Input qualifier: two-stage synchroniser and stable-width counter.
  Assumes minWidth is at least one and changes only between pulses.
*/
`timescale 1ns/1ns
`default_nettype none
module ptr_debounce import ptr_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Raw level in, qualified level out
  ptr_qual_if.filter qual
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic level;
    logic [PTR_DB_W-1:0] cnt;
  } ptr_db_state_type;

  ptr_db_state_type st_r;
  ptr_db_state_type st_nxt;

  // Counter restarts on every level change; saturates so it never wraps
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = qual.rawLevel;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;
    if (st_r.sync2 != st_r.prev) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt != '1) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
    if (st_r.sync2 == st_r.prev && st_r.sync2 != st_r.level &&
        ({1'b0, st_r.cnt} + 19'h0_0001) >= {1'b0, qual.minWidth}) begin
      st_nxt.level = st_r.sync2;
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign qual.qualLevel = st_r.level;
endmodule // ptr_debounce
`default_nettype wire

//--- sim/ptr_asserts.sv
/*
  Port checker for the totaliser top.
  Bound from the bench top; one clock, reset async high.
*/
`timescale 1ns/1ns
`default_nettype none
module ptr_asserts import ptr_pkg::*; (
  // Clock, reset, bus
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Displays
  input wire logic [31:0] dispTotal,
  input wire logic [31:0] dispRate,
  input wire logic configMode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Access phase and unlock writes, so $past sees a plain signal
  logic acc;
  logic unlockAcc;
  assign acc = psel & penable;
  assign unlockAcc = acc & pwrite & (paddr == PTR_OFS_UNLOCK);
  AST_READY: assert property (pready == acc) else $error("pready off");
  AST_ERR_HIGH: assert property (acc && paddr > 8'h30 |-> pslverr) else $error("no error");
  AST_ERR_ALIGN: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr) else $error("no error");
  AST_ERR_NONE: assert property (acc && paddr <= 8'h30 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("false error");
  // Read data may only move at a setup edge
  AST_RD_HOLD: assert property (!psel || penable |=> $stable(prdata)) else $error("prdata moved");
  AST_CFG_ENTRY: assert property ($rose(configMode) |-> $past(unlockAcc))
    else $error("config entered without unlock");
  AST_DTOT_HOLD: assert property ($changed(dispTotal) |=> $stable(dispTotal)[*8])
    else $error("total display refreshed too soon");
  AST_DRATE_HOLD: assert property ($changed(dispRate) |=> $stable(dispRate)[*8])
    else $error("rate display refreshed too soon");
  // Main scenarios reached
  cover property ($rose(configMode));
  cover property (acc && pslverr);
  cover property ($changed(dispTotal));
endmodule // ptr_asserts
`default_nettype wire

//--- sim/ptr_pulse_src.sv
/*
  Transducer model: square pulses on the raw input, idle low.
  Assumes the bench calls burst from its main sequence.
*/
`timescale 1ns/1ns
`default_nettype none
module ptr_pulse_src (
  // Clock
  input wire logic core_clk,
  // Raw level
  output logic pulseIn
);
  initial pulseIn = 1'b0;
  // n pulses, hi cycles high then lo cycles low
  task automatic burst(input int n, input int hi, input int lo);
    repeat (n) begin
      @(posedge core_clk) pulseIn <= 1'b1;
      repeat (hi) @(posedge core_clk);
      pulseIn <= 1'b0;
      repeat (lo - 1) @(posedge core_clk);
    end
  endtask
endmodule // ptr_pulse_src
`default_nettype wire

//--- sim/ptr_totaliser_tb_top.sv
/*
  Self-checking bench for the totaliser: APB reads noted in a queue.
  Assumes shortened counts; light debounce is 250 cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module ptr_totaliser_tb_top import ptr_pkg::*;;
  logic core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic remoteReset = 1'b0, btnUp = 1'b0, btnDown = 1'b0, btnEnter = 1'b0;
  logic pulseIn, pready, pslverr, configMode;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, dispTotal, dispRate, seed = 32'h4e7b_0292;
  logic [32:0] expQ[$];
  logic [32:0] e;
  int n_mismatch = 0, n_tests = 0;
  always #10 core_clk = ~core_clk;
  ptr_totaliser #(.TOTAL_HOLD_CYC(50), .GRAND_HOLD_CYC(100), .CFG_IDLE_CYC(200),
    .HALF_SEC_CYC(40), .RATE_ZERO_CYC(2000)) i_dut (.core_clk(core_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulseIn(pulseIn),
    .remoteReset(remoteReset), .btnUp(btnUp), .btnDown(btnDown), .btnEnter(btnEnter),
    .dispTotal(dispTotal), .dispRate(dispRate), .configMode(configMode));
  ptr_pulse_src i_src (.core_clk(core_clk), .pulseIn(pulseIn));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; a read notes {error, data} for the monitor
  task automatic apb(input logic wr, input logic [7:0] a, input logic [32:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d[31:0];
    if (!wr) expQ.push_back(d);
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, {1'b0, d});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, {1'b0, d});
  endtask
  // Both total-clear buttons for n cycles
  task automatic hold(input int n);
    btnUp <= 1'b1;
    btnDown <= 1'b1;
    repeat (n) @(posedge core_clk);
    btnUp <= 1'b0;
    btnDown <= 1'b0;
    repeat (5) @(posedge core_clk);
  endtask
  // Monitor: an error answer is judged on pslverr alone
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
      e = expQ.pop_front();
      chk({pslverr, e[32] ? e[31:0] : prdata}, e);
    end
  end
  task end_of_test;
    $display("compared %0d, mismatched %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    rd(PTR_OFS_CTRL, 32'h0000_0000);
    rd(PTR_OFS_FILTER, 32'h0000_0024);
    apb(1'b0, 8'h40, {1'b1, 32'h0000_0000});
    wr(PTR_OFS_UNLOCK, 32'h0000_0000);
    @(negedge core_clk) chk({32'h0000_0000, configMode}, 33'h1);
    wr(PTR_OFS_CTRL, 32'h0000_1090);
    wr(PTR_OFS_FILTER, 32'h0000_0000);
    wr(PTR_OFS_PRESET, 32'h0000_0010);
    wr(PTR_OFS_CMD, 32'h0000_0008);
    rd(PTR_OFS_CTRL, 32'h0000_1090);
    $display("setup done");
    i_src.burst(5, 300, 300);
    repeat (100) @(posedge core_clk);
    rd(PTR_OFS_TOTAL, 32'h0000_0005);
    rd(PTR_OFS_RATE, 32'h1DCD_6500);
    chk({1'b0, dispRate}, 33'h0_1DCD_6500);
    i_src.burst(2, 100, 100);
    repeat (2100) @(posedge core_clk);
    rd(PTR_OFS_TOTAL, 32'h0000_0005);
    rd(PTR_OFS_RATE, 32'h0000_0000);
    hold(30);
    rd(PTR_OFS_TOTAL, 32'h0000_0005);
    hold(60);
    rd(PTR_OFS_TOTAL, 32'h0000_0010);
    $display("count up done");
    wr(PTR_OFS_UNLOCK, 32'h0000_0000);
    wr(PTR_OFS_CTRL, 32'h0000_10D0);
    wr(PTR_OFS_CMD, 32'h0000_0008);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      i_src.burst(1, 260 + seed[6:0], 260 + seed[14:8]);
    end
    repeat (100) @(posedge core_clk);
    rd(PTR_OFS_TOTAL, 32'h0000_000D);
    remoteReset <= 1'b1;
    @(posedge core_clk) remoteReset <= 1'b0;
    rd(PTR_OFS_TOTAL, 32'h0000_0010);
    repeat (45) @(posedge core_clk);
    chk({1'b0, dispTotal}, 33'h0_0000_0010);
    rd(PTR_OFS_GRAND, 32'h0000_0008);
    wr(PTR_OFS_UNLOCK, 32'h0000_0000);
    wr(PTR_OFS_CMD, 32'h0000_0002);
    wr(PTR_OFS_CMD, 32'h0000_0010);
    rd(PTR_OFS_CTRL, 32'h0000_10D0);
    wr(PTR_OFS_UNLOCK, 32'h0000_0000);
    wr(PTR_OFS_CMD, 32'h0000_0001);
    wr(PTR_OFS_CMD, 32'h0000_0004);
    rd(PTR_OFS_GRAND, 32'h0000_0000);
    wr(PTR_OFS_CMD, 32'h0000_0008);
    $display("menu done");
    end_of_test;
  end
  // Watchdog well past the expected run
  initial begin
    #400_000;
    n_mismatch++;
    end_of_test;
  end
endmodule // ptr_totaliser_tb_top
bind ptr_totaliser ptr_asserts i_chk (.core_clk(core_clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .dispTotal(dispTotal), .dispRate(dispRate), .configMode(configMode));
`default_nettype wire
